// file: common/slcs_pkg.sv
// Constants and carrier types for one serial-link channel register bank.
// Assumes the host-side bus logic has already decoded the channel and
// hands over channel-relative byte offsets on a simple request strobe.
package slcs_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h014;
   localparam logic [11:0] OFS_DATA = 12'h018;
   localparam logic [11:0] OFS_WR_PTR_TX_CNT = 12'h01c;
   localparam logic [11:0] OFS_RD_PTR_RX_CNT = 12'h020;
   localparam logic [11:0] OFS_TX_LOW = 12'h024;
   localparam logic [11:0] OFS_RX_HIGH = 12'h028;
   localparam logic [11:0] OFS_LINE_CTRL = 12'h02c;

   // Status word bit positions
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_AE = 1;
   localparam int ST_TX_FULL = 2;
   localparam int ST_TX_VALID = 3;
   localparam int ST_RX_EMPTY = 4;
   localparam int ST_RX_AF = 5;
   localparam int ST_RX_FULL = 6;
   localparam int ST_RX_VALID = 7;
   localparam int ST_TX_AE_LAT = 8;
   localparam int ST_RX_AF_LAT = 9;
   localparam int ST_RX_OVF = 10;
   localparam int ST_VIOL = 11;
   localparam int ST_WR_DONE = 12;
   localparam int ST_RD_DONE = 13;
   localparam int ST_WR_ERR = 14;
   localparam int ST_RD_ERR = 15;
   localparam int ST_WR_IDLE = 16;
   localparam int ST_RD_IDLE = 17;
   localparam int ST_RX_READY = 18;
   localparam int ST_TX_READ = 19;
   localparam int ST_LINE_A_DONE = 20;
   localparam int ST_LINE_A_FRAME = 21;
   localparam int ST_LINE_B_DONE = 22;
   localparam int ST_LINE_B_FRAME = 23;
   localparam int ST_USER_INT = 30;
   localparam int ST_CHAN_INT = 31;
   localparam logic [31:0] LATCH_MASK = 32'h00fcff00;

   // Serial line control interrupt enable positions
   localparam int LC_LINE_A_INT_EN = 4;
   localparam int LC_LINE_B_INT_EN = 20;

   // Field widths and reset values
   localparam int LVL_W = 16;
   localparam logic [LVL_W-1:0] LVL_RST = 16'h0000;
   localparam logic [31:0] WORD_RST = 32'h00000000;

   // Pin input order in the synchroniser
   localparam int PIN_VIOL = 0;
   localparam int PIN_RX_READY = 1;
   localparam int PIN_TX_READ = 2;
   localparam int PIN_N = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } slcs_reg_req_t;

   typedef struct packed {
      logic tx_fifo_rst;
      logic rx_fifo_rst;
      logic master_int_en;
      logic force_int;
      logic tx_ae_int_en;
      logic rx_af_int_en;
      logic rx_ovf_int_en;
      logic wr_dma_int_en;
      logic rd_dma_int_en;
   } slcs_ctrl_t;

   typedef struct packed {
      logic wr_busy;
      logic rd_busy;
      logic wr_err;
      logic rd_err;
   } slcs_dma_stat_t;

endpackage

// file: rtl/slcs_chan_regs.sv
// Register bank, data FIFOs and status logic of one serial-link channel.
// Assumes a same-clock register request strobe, same-clock DMA engine and
// line state machines, and three receiver/transmitter pins from outside.
// Function
// - Live empty and full flags, both FIFOs
// - Bit 1: tx count at or below low
// - Bit 5: rx count at or above high
// - Bit 3: tx word valid incl. output stage
// - Bit 7: rx word valid incl. pipeline
// - Bit 8 latches tx almost empty
// - Bit 9 latches rx almost full
// - Bit 10 latches write to full rx
// - Bit 11 latches receiver violation pulse
// - Bits 12/13 latch DMA completion
// - Bits 14/15 latch DMA errors
// - Bits 16/17 live DMA idle
// - Bits 18/19 latch test-loop pulses
// - Bits 20/22 latch line completion
// - Bits 21/23 latch line framing errors
// - Bit 30: enabled non-DMA interrupt active
// - Bit 31: channel interrupt active
// - Data port writes tx, reads rx
// - Pointer writes start input/output DMA
// - Descriptor chains: three words, end bit
// - Count registers include output latches
// - Level registers 16-bit read/write thresholds
// - Master enable gates all but DMA
// - Line interrupt enable gates completion interrupt
`timescale 1ns/100ps
`default_nettype none

module slcs_chan_regs #(
   parameter int TX_DEPTH = 2048,
   parameter int RX_DEPTH = 4096,
   parameter int RX_PIPE = 4,
   parameter int BUF_DEPTH = 2
) (
   input wire logic sys_clk, // 20 MHz clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire slcs_pkg::slcs_reg_req_t reg_req, // Register access strobe
   output logic [31:0] reg_rdata, // Read data
   output logic reg_rvalid, // Read data valid pulse
   input wire slcs_pkg::slcs_ctrl_t chan_ctrl, // Channel control bits
   output logic [31:0] line_ctrl, // Serial line control register
   input wire logic wdma_valid, // Write DMA word valid
   input wire logic [31:0] wdma_data, // Write DMA word
   output logic wdma_ready, // Write DMA may push
   output logic rdma_valid, // Read DMA word available
   output logic [31:0] rdma_data, // Read DMA word
   input wire logic rdma_ready, // Read DMA takes word
   input wire slcs_pkg::slcs_dma_stat_t dma_stat, // DMA busy and errors
   output logic wdma_start, // Start input DMA pulse
   output logic rdma_start, // Start output DMA pulse
   output logic [31:0] dma_desc_ptr, // First descriptor address
   output logic tx_out_valid, // Transmit word valid
   output logic [31:0] tx_out_data, // Transmit word
   input wire logic tx_out_ready, // Transmitter takes word
   input wire logic rx_in_valid, // Receiver word strobe
   input wire logic [31:0] rx_in_data, // Receiver word
   input wire logic received_violation_flag, // Violation pin, async
   input wire logic rx_ready_pin, // Receiver ready pin, async
   input wire logic tx_data_read_pin, // Transmitter read pin, async
   input wire logic line_a_done, // Line A done pulse
   input wire logic line_a_frame_err, // Line A framing pulse
   input wire logic line_b_done, // Line B done pulse
   input wire logic line_b_frame_err, // Line B framing pulse
   output logic chan_int // Channel interrupt
);
   import slcs_pkg::*;

   localparam int TXA = $clog2(TX_DEPTH);
   localparam int RXA = $clog2(RX_DEPTH);
   localparam int TXC = TXA + 1;
   localparam int RXC = RXA + 1;
   localparam int PC = $clog2(RX_PIPE + 1);
   localparam int BC = $clog2(BUF_DEPTH + 1);
   localparam logic [TXC-1:0] TX_FULL_CNT = TXC'(TX_DEPTH);
   localparam logic [RXC-1:0] RX_FULL_CNT = RXC'(RX_DEPTH);
   localparam logic [PC-1:0] PIPE_FULL = PC'(RX_PIPE);
   localparam logic [BC-1:0] BUF_FULL = BC'(BUF_DEPTH);

   // Register file and strobes
   logic [LVL_W-1:0] tx_low_ff, rx_high_ff;
   logic [31:0] line_ctrl_ff, evt_ff, rdata_ff, ptr_ff;
   logic rvalid_ff, wstart_ff, rstart_ff, chan_int_ff;
   logic wr_data, rd_data, wr_status;

   // Transmit path
   logic [31:0] tx_mem [TX_DEPTH];
   logic [TXA-1:0] tx_wp_ff, tx_rp_ff;
   logic [TXC-1:0] tx_cnt_ff;
   logic [31:0] stage_ff;
   logic stage_v_ff;
   logic [31:0] buf_ff [BUF_DEPTH];
   logic [BC-1:0] buf_cnt_ff;
   logic buf_rdy_ff;
   logic tx_push, tx_pop, buf_push, buf_pop;
   logic [31:0] tx_push_data;

   // Receive path
   logic [31:0] rx_mem [RX_DEPTH];
   logic [RXA-1:0] rx_wp_ff, rx_rp_ff;
   logic [RXC-1:0] rx_cnt_ff;
   logic [31:0] pipe_ff [RX_PIPE];
   logic [PC-1:0] pipe_cnt_ff;
   logic rdma_v_ff;
   logic rx_push, rx_pop, pipe_pop, host_pop;

   // Status and interrupt terms
   logic [PIN_N-1:0] pin_raw, pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff, pin_rise;
   logic wr_busy_d_ff, rd_busy_d_ff;
   logic tx_ae, rx_af, tx_full, rx_full, user_int, any_int;
   logic [31:0] evt_set, evt_clr, status;
   logic [RXC:0] rx_total;
   logic [TXC-1:0] tx_total;

   // Decode; shared offsets split by direction
   assign wr_data = reg_req.wr && (reg_req.addr == OFS_DATA);
   assign rd_data = reg_req.rd && (reg_req.addr == OFS_DATA);
   assign wr_status = reg_req.wr && (reg_req.addr == OFS_STATUS);

   // Register writes; levels and line control are plain storage
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_low_ff <= LVL_RST;
         rx_high_ff <= LVL_RST;
         line_ctrl_ff <= WORD_RST;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            OFS_TX_LOW: tx_low_ff <= reg_req.wdata[LVL_W-1:0];
            OFS_RX_HIGH: rx_high_ff <= reg_req.wdata[LVL_W-1:0];
            OFS_LINE_CTRL: line_ctrl_ff <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // DMA start pulses; the engine walks the descriptor chain itself
   // (address, 22-bit length, next pointer with end bit)
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wstart_ff <= 1'b0;
         rstart_ff <= 1'b0;
         ptr_ff <= WORD_RST;
      end else begin
         wstart_ff <= reg_req.wr && (reg_req.addr == OFS_WR_PTR_TX_CNT);
         rstart_ff <= reg_req.wr && (reg_req.addr == OFS_RD_PTR_RX_CNT);
         if (reg_req.wr && (reg_req.addr == OFS_WR_PTR_TX_CNT ||
                            reg_req.addr == OFS_RD_PTR_RX_CNT))
            ptr_ff <= reg_req.wdata;
      end
   end
   // Write DMA enters through a small buffer; host writes take the FIFO
   // port first, so the buffer absorbs the stall instead of dropping words
   assign buf_push = wdma_valid && buf_rdy_ff;
   assign buf_pop = (buf_cnt_ff != '0) && !wr_data && !tx_full;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || chan_ctrl.tx_fifo_rst) begin
         buf_cnt_ff <= '0;
         buf_rdy_ff <= 1'b0;
      end else begin
         buf_cnt_ff <= buf_cnt_ff + BC'(buf_push) - BC'(buf_pop);
         buf_rdy_ff <= (buf_cnt_ff + BC'(buf_push) - BC'(buf_pop)) != BUF_FULL;
      end
   end

   // Buffer entries shift toward the head
   for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            buf_ff[i] <= WORD_RST;
         end else if (buf_push && (BC'(i) == buf_cnt_ff - BC'(buf_pop))) begin
            buf_ff[i] <= wdma_data;
         end else if (buf_pop) begin
            buf_ff[i] <= (i + 1 < BUF_DEPTH) ? buf_ff[(i + 1) % BUF_DEPTH] : WORD_RST;
         end
      end
   end

   // Transmit FIFO; a write to a full FIFO is dropped
   assign tx_full = (tx_cnt_ff == TX_FULL_CNT);
   assign tx_push = (wr_data || buf_pop) && !tx_full;
   assign tx_push_data = wr_data ? reg_req.wdata : buf_ff[0];
   assign tx_pop = (tx_cnt_ff != '0) && (!stage_v_ff || tx_out_ready);
   always_ff @(posedge sys_clk) begin
      if (sys_rst || chan_ctrl.tx_fifo_rst) begin
         tx_wp_ff <= '0;
         tx_rp_ff <= '0;
         tx_cnt_ff <= '0;
      end else begin
         if (tx_push) tx_wp_ff <= tx_wp_ff + 1'b1;
         if (tx_pop) tx_rp_ff <= tx_rp_ff + 1'b1;
         tx_cnt_ff <= tx_cnt_ff + TXC'(tx_push) - TXC'(tx_pop);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (tx_push) tx_mem[tx_wp_ff] <= tx_push_data;
   end

   // Single-word output stage toward the transmitter
   always_ff @(posedge sys_clk) begin
      if (sys_rst || chan_ctrl.tx_fifo_rst) begin
         stage_v_ff <= 1'b0;
         stage_ff <= WORD_RST;
      end else if (tx_pop) begin
         stage_v_ff <= 1'b1;
         stage_ff <= tx_mem[tx_rp_ff];
      end else if (tx_out_ready) begin
         stage_v_ff <= 1'b0;
      end
   end

   // Receive FIFO; the receiver has no back-pressure, so full means loss
   assign rx_full = (rx_cnt_ff == RX_FULL_CNT);
   assign rx_push = rx_in_valid && !rx_full;
   assign host_pop = rd_data && (pipe_cnt_ff != '0);
   assign pipe_pop = host_pop || (rdma_v_ff && rdma_ready && !rd_data);
   assign rx_pop = (rx_cnt_ff != '0) && ((pipe_cnt_ff != PIPE_FULL) || pipe_pop);
   always_ff @(posedge sys_clk) begin
      if (sys_rst || chan_ctrl.rx_fifo_rst) begin
         rx_wp_ff <= '0;
         rx_rp_ff <= '0;
         rx_cnt_ff <= '0;
      end else begin
         if (rx_push) rx_wp_ff <= rx_wp_ff + 1'b1;
         if (rx_pop) rx_rp_ff <= rx_rp_ff + 1'b1;
         rx_cnt_ff <= rx_cnt_ff + RXC'(rx_push) - RXC'(rx_pop);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rx_push) rx_mem[rx_wp_ff] <= rx_in_data;
   end

   // Prefetch pipeline so the next word is ready for a read or read DMA
   always_ff @(posedge sys_clk) begin
      if (sys_rst || chan_ctrl.rx_fifo_rst) begin
         pipe_cnt_ff <= '0;
         rdma_v_ff <= 1'b0;
      end else begin
         pipe_cnt_ff <= pipe_cnt_ff + PC'(rx_pop) - PC'(pipe_pop);
         rdma_v_ff <= (pipe_cnt_ff + PC'(rx_pop) - PC'(pipe_pop)) != '0;
      end
   end
   for (genvar i = 0; i < RX_PIPE; i++) begin : g_pipe
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            pipe_ff[i] <= WORD_RST;
         end else if (rx_pop && (PC'(i) == pipe_cnt_ff - PC'(pipe_pop))) begin
            pipe_ff[i] <= rx_mem[rx_rp_ff];
         end else if (pipe_pop) begin
            pipe_ff[i] <= (i + 1 < RX_PIPE) ? pipe_ff[(i + 1) % RX_PIPE] : WORD_RST;
         end
      end
   end

   // Pins from the serial chips: three stages, a change counts on agreement
   assign pin_raw = {tx_data_read_pin, rx_ready_pin, received_violation_flag};
   for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            pin_s1_ff[i] <= 1'b0;
            pin_s2_ff[i] <= 1'b0;
            pin_s3_ff[i] <= 1'b0;
            pin_lvl_ff[i] <= 1'b0;
         end else begin
            pin_s1_ff[i] <= pin_raw[i];
            pin_s2_ff[i] <= pin_s1_ff[i];
            pin_s3_ff[i] <= pin_s2_ff[i];
            if (pin_s2_ff[i] == pin_s3_ff[i]) pin_lvl_ff[i] <= pin_s3_ff[i];
         end
      end
      assign pin_rise[i] = pin_s2_ff[i] && pin_s3_ff[i] && !pin_lvl_ff[i];
   end

   // Busy history for the running-to-completed edge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_busy_d_ff <= 1'b0;
         rd_busy_d_ff <= 1'b0;
      end else begin
         wr_busy_d_ff <= dma_stat.wr_busy;
         rd_busy_d_ff <= dma_stat.rd_busy;
      end
   end

   // Level compares against the FIFO count only, not the output latches
   assign tx_ae = {{(32-TXC){1'b0}}, tx_cnt_ff} <= {16'h0000, tx_low_ff};
   assign rx_af = {{(32-RXC){1'b0}}, rx_cnt_ff} >= {16'h0000, rx_high_ff};

   // Event sources for the latched bits
   always_comb begin
      evt_set = WORD_RST;
      evt_set[ST_TX_AE_LAT] = tx_ae;
      evt_set[ST_RX_AF_LAT] = rx_af;
      evt_set[ST_RX_OVF] = rx_in_valid && rx_full;
      evt_set[ST_VIOL] = pin_rise[PIN_VIOL];
      evt_set[ST_WR_DONE] = wr_busy_d_ff && !dma_stat.wr_busy;
      evt_set[ST_RD_DONE] = rd_busy_d_ff && !dma_stat.rd_busy;
      evt_set[ST_WR_ERR] = dma_stat.wr_err;
      evt_set[ST_RD_ERR] = dma_stat.rd_err;
      evt_set[ST_RX_READY] = pin_rise[PIN_RX_READY];
      evt_set[ST_TX_READ] = pin_rise[PIN_TX_READ];
      evt_set[ST_LINE_A_DONE] = line_a_done;
      evt_set[ST_LINE_B_DONE] = line_b_done;
      evt_set[ST_LINE_A_FRAME] = line_a_frame_err;
      evt_set[ST_LINE_B_FRAME] = line_b_frame_err;
   end

   // Write-one-to-clear; a new event in the clearing cycle wins
   assign evt_clr = wr_status ? (reg_req.wdata & LATCH_MASK) : WORD_RST;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         evt_ff <= WORD_RST;
      end else begin
         evt_ff <= ((evt_ff & ~evt_clr) | evt_set) & LATCH_MASK;
      end
   end

   // Interrupt summary; DMA completion bypasses the master enable
   assign user_int = chan_ctrl.master_int_en && (chan_ctrl.force_int ||
      (chan_ctrl.tx_ae_int_en && evt_ff[ST_TX_AE_LAT]) ||
      (chan_ctrl.rx_af_int_en && evt_ff[ST_RX_AF_LAT]) ||
      (chan_ctrl.rx_ovf_int_en && evt_ff[ST_RX_OVF]) ||
      (line_ctrl_ff[LC_LINE_A_INT_EN] && evt_ff[ST_LINE_A_DONE]) ||
      (line_ctrl_ff[LC_LINE_B_INT_EN] && evt_ff[ST_LINE_B_DONE]));
   assign any_int = user_int || (chan_ctrl.wr_dma_int_en && evt_ff[ST_WR_DONE]) ||
      (chan_ctrl.rd_dma_int_en && evt_ff[ST_RD_DONE]);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) chan_int_ff <= 1'b0;
      else chan_int_ff <= any_int;
   end

   // Live status word assembly
   always_comb begin
      status = evt_ff;
      status[ST_TX_EMPTY] = (tx_cnt_ff == '0);
      status[ST_TX_AE] = tx_ae;
      status[ST_TX_FULL] = tx_full;
      status[ST_TX_VALID] = (tx_cnt_ff != '0) || stage_v_ff;
      status[ST_RX_EMPTY] = (rx_cnt_ff == '0);
      status[ST_RX_AF] = rx_af;
      status[ST_RX_FULL] = rx_full;
      status[ST_RX_VALID] = (rx_cnt_ff != '0) || (pipe_cnt_ff != '0);
      status[ST_WR_IDLE] = !dma_stat.wr_busy;
      status[ST_RD_IDLE] = !dma_stat.rd_busy;
      status[ST_USER_INT] = user_int;
      status[ST_CHAN_INT] = chan_int_ff;
   end

   // Counts include the words waiting in the output latches
   assign tx_total = tx_cnt_ff + TXC'(stage_v_ff);
   assign rx_total = {1'b0, rx_cnt_ff} + (RXC+1)'(pipe_cnt_ff);

   // Read mux, one cycle latency; unmapped offsets read zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_ff <= WORD_RST;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= reg_req.rd;
         if (reg_req.rd) begin
            case (reg_req.addr)
               OFS_STATUS: rdata_ff <= status;
               OFS_DATA: rdata_ff <= (pipe_cnt_ff != '0) ? pipe_ff[0] : WORD_RST;
               OFS_WR_PTR_TX_CNT: rdata_ff <= 32'(tx_total);
               OFS_RD_PTR_RX_CNT: rdata_ff <= 32'(rx_total);
               OFS_TX_LOW: rdata_ff <= {16'h0000, tx_low_ff};
               OFS_RX_HIGH: rdata_ff <= {16'h0000, rx_high_ff};
               OFS_LINE_CTRL: rdata_ff <= line_ctrl_ff;
               default: rdata_ff <= WORD_RST;
            endcase
         end
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign line_ctrl = line_ctrl_ff;
   assign wdma_ready = buf_rdy_ff;
   assign rdma_valid = rdma_v_ff;
   assign rdma_data = pipe_ff[0];
   assign wdma_start = wstart_ff;
   assign rdma_start = rstart_ff;
   assign dma_desc_ptr = ptr_ff;
   assign tx_out_valid = stage_v_ff;
   assign tx_out_data = stage_ff;
   assign chan_int = chan_int_ff;

endmodule // slcs_chan_regs

`default_nettype wire

// file: test/slcs_chk_sva.sv
// Port checker for the channel register bank.
// Assumes one clock domain; bound onto every bank instance below.
`timescale 1ns/100ps
`default_nettype none
module slcs_chk (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset, high
   input wire slcs_pkg::slcs_reg_req_t reg_req, // Request
   input wire logic [31:0] reg_rdata, // Read data
   input wire logic reg_rvalid, // Read valid
   input wire slcs_pkg::slcs_ctrl_t chan_ctrl, // Control bits
   input wire slcs_pkg::slcs_dma_stat_t dma_stat, // DMA status
   input wire logic wdma_start, // Input start
   input wire logic rdma_start, // Output start
   input wire logic [31:0] dma_desc_ptr, // Pointer
   input wire logic chan_int // Interrupt
);
   import slcs_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Read answers, one cycle after the request
   rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read left unanswered");
   rd_quiet_a: assert property (!reg_req.rd |=> !reg_rvalid)
      else $error("read valid without request");
   // Pointer writes start the engines with the written address
   wptr_start_a: assert property (reg_req.wr && reg_req.addr == OFS_WR_PTR_TX_CNT
      |=> wdma_start && dma_desc_ptr == $past(reg_req.wdata)) else $error("no input start");
   rptr_start_a: assert property (reg_req.wr && reg_req.addr == OFS_RD_PTR_RX_CNT
      |=> rdma_start && dma_desc_ptr == $past(reg_req.wdata)) else $error("no output start");
   start_cause_a: assert property (wdma_start
      |-> $past(reg_req.wr && reg_req.addr == OFS_WR_PTR_TX_CNT)) else $error("stray start");
   // Status and count read fields, and the interrupt gate with enables off
   idle_read_a: assert property (reg_req.rd && reg_req.addr == OFS_STATUS
      |=> reg_rdata[17:16] == ~$past({dma_stat.rd_busy, dma_stat.wr_busy})
      && reg_rdata[31] == $past(chan_int)) else $error("idle or int bit wrong");
   flags_read_a: assert property (reg_rvalid && $past(reg_req.addr == OFS_STATUS)
      |-> (reg_rdata[0] || reg_rdata[3]) && (reg_rdata[4] || reg_rdata[7])
      && !(reg_rdata[2] && reg_rdata[0])) else $error("fifo flags inconsistent");
   cnt_width_a: assert property (reg_rvalid && $past(reg_req.addr == OFS_WR_PTR_TX_CNT)
      |-> reg_rdata[31:12] == 20'h0) else $error("tx count spare bits set");
   gate_a: assert property (!chan_ctrl.master_int_en && !chan_ctrl.wr_dma_int_en
      && !chan_ctrl.rd_dma_int_en |=> !chan_int) else $error("ungated interrupt");
endmodule // slcs_chk
bind slcs_chan_regs slcs_chk u_chk (.*);
`default_nettype wire

// file: test/slcs_dma_model.sv
// Behavioural DMA engine facing one channel bank's streams.
// Assumes the same clock; the bench orders aborts and read stalls.
`timescale 1ns/100ps
`default_nettype none
module slcs_dma_model (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset, high
   input wire logic wdma_start, // Start input DMA
   input wire logic rdma_start, // Start output DMA
   input wire logic [31:0] dma_desc_ptr, // First descriptor
   input wire logic fault, // Abort the next start
   input wire logic stall, // Hold back reads
   output logic wdma_valid, // Word offered
   output logic [31:0] wdma_data, // Word value
   input wire logic wdma_ready, // Bank takes word
   input wire logic rdma_valid, // Bank offers word
   output logic rdma_ready, // Word taken
   output var slcs_pkg::slcs_dma_stat_t dma_stat // Busy and abort pulses
);
   import slcs_pkg::*;
   int wn;
   int rn;
   logic we_ff;
   logic re_ff;
   // Descriptor reduced to its byte length field
   always_ff @(posedge sys_clk) begin
      if (sys_rst || wdma_start)
         wn <= (sys_rst || fault) ? 0 : int'(dma_desc_ptr[21:0] >> 2);
      else if (wdma_valid && wdma_ready)
         wn <= wn - 1;
      if (sys_rst || rdma_start)
         rn <= (sys_rst || fault) ? 0 : int'(dma_desc_ptr[21:0] >> 2);
      else if (rdma_valid && rdma_ready)
         rn <= rn - 1;
      we_ff <= wdma_start && fault && !sys_rst;
      re_ff <= rdma_start && fault && !sys_rst;
   end
   // Offers move only after a handshake
   assign wdma_valid = wn != 0;
   assign wdma_data = dma_desc_ptr ^ 32'(wn);
   assign rdma_ready = rn != 0 && !stall;
   assign dma_stat = {wn != 0, rn != 0, we_ff, re_ff};
endmodule // slcs_dma_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench with queue models of both fifos.
// Assumes the bound checker; inputs move at falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import slcs_pkg::*;
   localparam int TXD = 8;
   localparam int RXD = 8;
   logic sys_clk = 0;
   logic sys_rst = 1;
   slcs_reg_req_t reg_req = '0;
   slcs_ctrl_t chan_ctrl = '0;
   slcs_dma_stat_t dma_stat;
   logic [31:0] reg_rdata, line_ctrl, wdma_data, rdma_data, dma_desc_ptr, tx_out_data;
   logic [31:0] rx_in_data = '0;
   logic reg_rvalid, wdma_valid, wdma_ready, rdma_valid, rdma_ready, wdma_start, rdma_start;
   logic tx_out_valid, chan_int;
   logic tx_out_ready = 0, rx_in_valid = 0, fault = 0, stall = 0;
   logic [6:0] pins = '0;
   int n_mismatch = 0, cmp_count = 0, seed = 32'h820b7fda, low = 2, high = 3;
   logic [31:0] tq[$], rq[$], lat = '0, d;
   always #25 sys_clk = ~sys_clk;
   slcs_chan_regs #(.TX_DEPTH(TXD), .RX_DEPTH(RXD)) DUT (.*,
      .received_violation_flag(pins[0]), .rx_ready_pin(pins[1]), .tx_data_read_pin(pins[2]),
      .line_a_done(pins[3]), .line_a_frame_err(pins[4]), .line_b_done(pins[5]),
      .line_b_frame_err(pins[6]));
   slcs_dma_model PART (.*);
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic give_up();
      n_mismatch++;
      close_out();
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(negedge sys_clk) reg_req = {1'b1, 1'b0, a, v};
      @(negedge sys_clk) reg_req = '0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(negedge sys_clk) reg_req = {1'b0, 1'b1, a, 32'h0};
      @(negedge sys_clk) reg_req = '0;
      v = reg_rdata;
      chk({31'h0, reg_rvalid}, 32'h1);
   endtask
   // Status from the queues; stage holds one word, pipe four
   task automatic stchk();
      logic [31:0] e;
      int tc;
      int rc;
      tc = tq.size() > 0 ? tq.size() - 1 : 0;
      rc = rq.size() > 4 ? rq.size() - 4 : 0;
      e = lat;
      e[7:0] = {rq.size() > 0, rc == RXD, rc >= high, rc == 0, tq.size() > 0, tc == TXD,
         tc <= low, tc == 0};
      e[17:16] = {!dma_stat.rd_busy, !dma_stat.wr_busy};
      e[9:8] = e[9:8] | {e[5], e[1]};
      lat[9:8] = e[9:8];
      rd(OFS_STATUS, d);
      chk(d & 32'h3fffffff, e);
   endtask
   task automatic clr(input logic [31:0] v);
      wr(OFS_STATUS, v);
      lat = lat & ~(v & LATCH_MASK);
      stchk();
   endtask
   // Output streams against the queue model
   always @(posedge sys_clk) begin
      if (tx_out_valid && tx_out_ready)
         chk(tx_out_data, tq.pop_front());
      if (rdma_valid && rdma_ready)
         chk(rdma_data, rq.pop_front());
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      sys_rst = 0;
      wr(OFS_TX_LOW, 32'hffff0002);
      wr(OFS_RX_HIGH, 32'h00000003);
      rd(OFS_TX_LOW, d);
      chk(d, 32'h2);
      rd(12'h0fc, d);
      chk(d, 32'h0);
      clr(32'hffffffff);
      // Overfill transmit path
      for (int i = 0; i < TXD + 3; i++) begin
         d = $random(seed);
         wr(OFS_DATA, d);
         if (tq.size() < TXD + 1)
            tq.push_back(d);
      end
      rd(OFS_WR_PTR_TX_CNT, d);
      chk(d, 32'(TXD + 1));
      clr(32'h100);
      for (int i = 0; i < 300 && tq.size() > 0; i++)
         @(negedge sys_clk) tx_out_ready = 1'($random(seed));
      @(negedge sys_clk) tx_out_ready = 0;
      if (tq.size() != 0)
         give_up();
      stchk();
      // Receive path to overflow
      for (int i = 0; i < RXD + 6; i++) begin
         @(negedge sys_clk) rx_in_valid = 1;
         rx_in_data = $random(seed);
         if (rq.size() < RXD + 4)
            rq.push_back(rx_in_data);
         @(negedge sys_clk) rx_in_valid = 0;
      end
      rd(OFS_RD_PTR_RX_CNT, d);
      chk(d, 32'(RXD + 4));
      lat[10] = 1;
      stchk();
      clr(32'h400);
      for (int i = 0; i < 6; i++) begin
         rd(OFS_DATA, d);
         chk(d, rq.pop_front());
      end
      // Output DMA drains the rest, random stalls
      wr(OFS_RD_PTR_RX_CNT, 32'h00000018);
      for (int i = 0; i < 300 && (rq.size() > 0 || dma_stat.rd_busy); i++)
         @(negedge sys_clk) stall = 1'($random(seed));
      if (rq.size() != 0)
         give_up();
      rd(OFS_DATA, d);
      chk(d, 32'h0);
      lat[13] = 1;
      stchk();
      // Twelve-word input DMA backs up the buffer
      for (int k = 12; k > 0; k--)
         tq.push_back(32'h00c00030 ^ k);
      wr(OFS_WR_PTR_TX_CNT, 32'h00c00030);
      repeat (30) @(negedge sys_clk);
      chk({31'h0, wdma_ready}, 32'h0);
      for (int i = 0; i < 300 && (tq.size() > 0 || dma_stat.wr_busy); i++)
         @(negedge sys_clk) tx_out_ready = 1'($random(seed));
      @(negedge sys_clk) tx_out_ready = 0;
      if (tq.size() != 0)
         give_up();
      lat[12] = 1;
      stchk();
      // Aborted starts on both engines
      fault = 1;
      wr(OFS_RD_PTR_RX_CNT, 32'h4);
      wr(OFS_WR_PTR_TX_CNT, 32'h4);
      repeat (2) @(negedge sys_clk);
      fault = 0;
      lat[15:14] = 2'b11;
      clr(32'h00003000);
      clr(32'h0000c000);
      // Pin and line events
      @(negedge sys_clk) pins = 7'h7f;
      repeat (3) @(negedge sys_clk);
      pins = '0;
      repeat (5) @(negedge sys_clk);
      lat = lat | 32'h00fc0800;
      stchk();
      clr(32'h00500800);
      // Line A interrupt via master enable
      wr(OFS_LINE_CTRL, 32'h00000010);
      chk(line_ctrl, 32'h10);
      chan_ctrl.master_int_en = 1;
      @(negedge sys_clk) pins[3] = 1;
      @(negedge sys_clk) pins[3] = 0;
      repeat (3) @(negedge sys_clk);
      chk({31'h0, chan_int}, 32'h1);
      lat[20] = 1;
      stchk();
      chan_ctrl.master_int_en = 0;
      repeat (2) @(negedge sys_clk);
      chk({31'h0, chan_int}, 32'h0);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
